/* verilog/exec_pkg.sv */
package exec_pkg;

  // register map, byte addresses on the bus
  localparam logic [7:0] OFF_CMD  = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_STATUS_REGISTER = 8'h08;
  localparam logic [7:0] OFF_PC   = 8'h0C;
  localparam logic [7:0] OFF_RSEL = 8'h10;
  localparam logic [7:0] OFF_RDAT = 8'h14;
  localparam logic [7:0] OFF_ISEL = 8'h18;
  localparam logic [7:0] OFF_IDAT = 8'h1C;

  // command word field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_D_LSB  = 8;
  localparam int CMD_R_LSB  = 16;
  localparam int CMD_B_LSB  = 21;
  localparam int CMD_K_LSB  = 24;

  // status register bit positions
  localparam logic [2:0] SB_C = 3'h0;
  localparam logic [2:0] SB_Z = 3'h1;
  localparam logic [2:0] SB_N = 3'h2;
  localparam logic [2:0] SB_V = 3'h3;
  localparam logic [2:0] SB_S = 3'h4;
  localparam logic [2:0] SB_H = 3'h5;
  localparam logic [2:0] SB_T = 3'h6;
  localparam logic [2:0] SB_I = 3'h7;

  // values after reset
  localparam logic [7:0]  STATUS_REGISTER_RST = 8'h00;
  localparam logic [7:0]  GPR_RST  = 8'h00;
  localparam logic [7:0]  IO_RST   = 8'h00;
  localparam logic [31:0] PC_RST   = 32'h0000_0000;

  // execution cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // operations accepted in the command word, codes 0 upward
  typedef enum logic [4:0] {
    branch_on_negative, branch_on_positive, branch_signed_ge,
    branch_signed_lt, branch_halfcarry_set, branch_halfcarry_clear,
    branch_transfer_set, branch_transfer_clear, branch_overflow_set,
    branch_overflow_clear, branch_irq_enabled, branch_irq_disabled,
    io_bit_set, io_bit_clear, shift_left_logical, shift_right_logical,
    rotate_left_carry, rotate_right_carry, shift_right_arith,
    status_bit_set, status_bit_clear, bit_to_transfer, transfer_to_bit,
    global_irq_on, global_irq_off, register_copy
  } op_t;

endpackage

/* verilog/shift_if.sv */
`timescale 1ns/10ps
interface shift_if;
  exec_pkg::op_t op;
  logic [7:0]    operand;
  logic          carry_in;
  logic [7:0]    result;
  logic          z;
  logic          c;
  logic          n;
  logic          v;

  modport requester (output op, output operand, output carry_in,
                     input result, input z, input c, input n, input v);
  modport unit (input op, input operand, input carry_in,
                output result, output z, output c, output n, output v);
endinterface

/* verilog/shift_unit.sv */
`timescale 1ns/10ps
module shift_unit (
  shift_if.unit sh
);

  logic [7:0] res;
  logic       cout;

  // one-cycle shift and rotate datapath
  always_comb begin
    res  = sh.operand;
    cout = sh.carry_in;
    case (sh.op)
      exec_pkg::shift_left_logical: begin
        res  = {sh.operand[6:0], 1'b0};
        cout = sh.operand[7];
      end
      exec_pkg::shift_right_logical: begin
        res  = {1'b0, sh.operand[7:1]};
        cout = sh.operand[0];
      end
      exec_pkg::rotate_left_carry: begin
        res  = {sh.operand[6:0], sh.carry_in};
        cout = sh.operand[7];
      end
      exec_pkg::rotate_right_carry: begin
        res  = {sh.carry_in, sh.operand[7:1]};
        cout = sh.operand[0];
      end
      exec_pkg::shift_right_arith: begin
        // sign bit stays, low bit falls into carry
        res  = {sh.operand[7], sh.operand[7:1]};
        cout = sh.operand[0];
      end
      default: begin
        res  = sh.operand;
        cout = sh.carry_in;
      end
    endcase
  end

  // flags: overflow is negative xor carry after the move
  assign sh.result = res;
  assign sh.c      = cout;
  assign sh.n      = res[7];
  assign sh.z      = (res == 8'h00);
  assign sh.v      = res[7] ^ cout;

endmodule // shift_unit

/* verilog/branch_bit_flag_exec.sv */
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module branch_bit_flag_exec #(
  parameter int PC_W = 13,
  parameter int IO_N = 32
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp
);

  // pc arithmetic and io index width limits
  if (PC_W < 8 || PC_W > 32) begin : g_bad_pc
    $error("PC_W must lie between 8 and 32");
  end
  if (IO_N < 1 || IO_N > 32) begin : g_bad_io
    $error("IO_N must lie between 1 and 32");
  end

  typedef enum logic [1:0] {st_idle, st_exec, st_extra} state_t;

  state_t          st_r;
  state_t          st_nxt;
  exec_pkg::op_t   op_r;
  logic [4:0]      d_r;
  logic [4:0]      r_r;
  logic [2:0]      b_r;
  logic [6:0]      k_r;
  logic [7:0]      status_register_r;
  logic [7:0]      status_register_nxt;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [7:0]      gpr_r [32];
  logic [7:0]      io_r  [IO_N];
  logic [4:0]      rsel_r;
  logic [4:0]      isel_r;
  logic            taken_r;
  logic [1:0]      cycles_r;

  // bus pipeline state
  logic            dp_valid_r;
  logic            dp_write_r;
  logic            dp_hit_r;
  logic [7:0]      dp_addr_r;
  logic            rd_done_r;
  logic [31:0]     hrdata_r;

  shift_if sh ();

  shift_unit u_shift (
    .sh (sh)
  );

  // returns {is branch, condition met} from the operation and flags
  function automatic logic [1:0] branch_eval(exec_pkg::op_t op,
                                             logic [7:0] s);
    logic nv;
    nv = s[exec_pkg::SB_N] ^ s[exec_pkg::SB_V];
    case (op)
      exec_pkg::branch_on_negative:     return {1'b1, s[exec_pkg::SB_N]};
      exec_pkg::branch_on_positive:     return {1'b1, !s[exec_pkg::SB_N]};
      exec_pkg::branch_signed_ge:       return {1'b1, !nv};
      exec_pkg::branch_signed_lt:       return {1'b1, nv};
      exec_pkg::branch_halfcarry_set:   return {1'b1, s[exec_pkg::SB_H]};
      exec_pkg::branch_halfcarry_clear: return {1'b1, !s[exec_pkg::SB_H]};
      exec_pkg::branch_transfer_set:    return {1'b1, s[exec_pkg::SB_T]};
      exec_pkg::branch_transfer_clear:  return {1'b1, !s[exec_pkg::SB_T]};
      exec_pkg::branch_overflow_set:    return {1'b1, s[exec_pkg::SB_V]};
      exec_pkg::branch_overflow_clear:  return {1'b1, !s[exec_pkg::SB_V]};
      exec_pkg::branch_irq_enabled:     return {1'b1, s[exec_pkg::SB_I]};
      exec_pkg::branch_irq_disabled:    return {1'b1, !s[exec_pkg::SB_I]};
      default:                          return 2'b00;
    endcase
  endfunction

  // relative target: sign-extended offset plus one
  function automatic logic [PC_W-1:0] branch_target(logic [PC_W-1:0] pc,
                                                    logic [6:0] k);
    logic [PC_W-1:0] ext;
    ext = PC_W'($signed(k));
    return pc + ext + PC_W'(1);
  endfunction

  // ---------------------------------------------------------------
  // bus side decode
  // ---------------------------------------------------------------
  wire logic addr_ok  = (i_haddr[31:8] == 24'h00_0000) &&
                        (i_haddr[1:0] == 2'b00);
  wire logic wr_en    = dp_valid_r && dp_write_r && dp_hit_r;
  wire logic idle     = (st_r == st_idle);
  wire logic cmd_go   = wr_en && idle && (dp_addr_r == exec_pkg::OFF_CMD);
  wire logic status_register_wr  = wr_en && idle && (dp_addr_r == exec_pkg::OFF_STATUS_REGISTER);
  wire logic pc_wr    = wr_en && idle && (dp_addr_r == exec_pkg::OFF_PC);
  wire logic rsel_wr  = wr_en && (dp_addr_r == exec_pkg::OFF_RSEL);
  wire logic rdat_wr  = wr_en && idle && (dp_addr_r == exec_pkg::OFF_RDAT);
  wire logic isel_wr  = wr_en && (dp_addr_r == exec_pkg::OFF_ISEL);
  wire logic idat_wr  = wr_en && idle && (dp_addr_r == exec_pkg::OFF_IDAT);
  wire logic rd_wait  = dp_valid_r && !dp_write_r && !rd_done_r;
  wire logic isel_ok  = (32'(isel_r) < IO_N);

  // reads hold one wait cycle so a write just before is always seen
  assign o_hreadyout = !rd_wait;
  assign o_hresp     = 1'b0;
  assign o_hrdata    = hrdata_r;

  wire logic [31:0] stat_word = {28'h000_0000, cycles_r, taken_r, !idle};
  wire logic [7:0]  io_sel_v  = isel_ok ? io_r[isel_r] : 8'h00;

  // read selection; unmapped addresses read zero
  wire logic [31:0] rd_mux =
    !dp_hit_r                          ? 32'h0000_0000 :
    dp_addr_r == exec_pkg::OFF_STAT    ? stat_word :
    dp_addr_r == exec_pkg::OFF_STATUS_REGISTER    ? {24'h00_0000, status_register_r} :
    dp_addr_r == exec_pkg::OFF_PC      ? 32'(pc_r) :
    dp_addr_r == exec_pkg::OFF_RSEL    ? {27'h000_0000, rsel_r} :
    dp_addr_r == exec_pkg::OFF_RDAT    ? {24'h00_0000, gpr_r[rsel_r]} :
    dp_addr_r == exec_pkg::OFF_ISEL    ? {27'h000_0000, isel_r} :
    dp_addr_r == exec_pkg::OFF_IDAT    ? {24'h00_0000, io_sel_v} :
                                         32'h0000_0000;

  // address phase capture, only when the bus is ready
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_hit_r   <= 1'b0;
      dp_addr_r  <= 8'h00;
    end else if (i_hready) begin
      dp_valid_r <= i_hsel && i_htrans[1];
      dp_write_r <= i_hwrite;
      dp_hit_r   <= addr_ok;
      dp_addr_r  <= i_haddr[7:0];
    end
  end

  // read data register and wait-state tracker
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rd_done_r <= 1'b0;
      hrdata_r  <= 32'h0000_0000;
    end else if (rd_wait) begin
      rd_done_r <= 1'b1;
      hrdata_r  <= rd_mux;
    end else if (i_hready) begin
      rd_done_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // execution
  // ---------------------------------------------------------------
  wire logic [1:0] br     = branch_eval(op_r, status_register_r);
  wire logic is_branch    = br[1];
  wire logic br_take      = br[1] && br[0];
  wire logic is_io        = (op_r == exec_pkg::io_bit_set) ||
                            (op_r == exec_pkg::io_bit_clear);
  wire logic is_shift     = (op_r == exec_pkg::shift_left_logical) ||
                            (op_r == exec_pkg::shift_right_logical) ||
                            (op_r == exec_pkg::rotate_left_carry) ||
                            (op_r == exec_pkg::rotate_right_carry) ||
                            (op_r == exec_pkg::shift_right_arith);
  wire logic in_exec      = (st_r == st_exec);
  wire logic in_extra     = (st_r == st_extra);
  wire logic two_cycle    = br_take || is_io;
  wire logic [7:0] rd_val = gpr_r[d_r];
  wire logic [7:0] rr_val = gpr_r[r_r];

  assign sh.op       = op_r;
  assign sh.operand  = rd_val;
  assign sh.carry_in = status_register_r[exec_pkg::SB_C];

  // register-file write port: exec has it, bus only while idle
  wire logic gpr_exec_wr = in_exec &&
                           (is_shift ||
                            op_r == exec_pkg::transfer_to_bit ||
                            op_r == exec_pkg::register_copy);
  wire logic [7:0] bit_ins = (rd_val & ~(8'h01 << b_r)) |
                             (8'(status_register_r[exec_pkg::SB_T]) << b_r);
  wire logic [7:0] gpr_exec_v =
    is_shift                          ? sh.result :
    op_r == exec_pkg::transfer_to_bit ? bit_ins :
                                        rr_val;

  // io bit modify, written back in the second cycle
  wire logic io_ok   = (32'(d_r) < IO_N);
  wire logic io_wr   = in_extra && is_io && io_ok;
  wire logic [7:0] io_cur = io_ok ? io_r[d_r] : 8'h00;
  wire logic [7:0] io_new =
    (op_r == exec_pkg::io_bit_set) ? (io_cur | (8'h01 << b_r)) :
                                     (io_cur & ~(8'h01 << b_r));

  // sequencing of one or two execution cycles
  always_comb begin
    unique case (st_r)
      st_idle:  st_nxt = cmd_go ? st_exec : st_idle;
      st_exec:  st_nxt = two_cycle ? st_extra : st_idle;
      st_extra: st_nxt = st_idle;
    endcase
  end

  // program counter: +1 normally, relative target when taken
  always_comb begin
    pc_nxt = pc_r;
    if (pc_wr) begin
      pc_nxt = i_hwdata[PC_W-1:0];
    end else if (in_exec && !two_cycle) begin
      pc_nxt = pc_r + PC_W'(1);
    end else if (in_extra && is_branch) begin
      pc_nxt = branch_target(pc_r, k_r);
    end else if (in_extra) begin
      pc_nxt = pc_r + PC_W'(1);
    end
  end

  // status register: only the targeted flags move; branches keep all
  always_comb begin
    status_register_nxt = status_register_r;
    if (status_register_wr) begin
      status_register_nxt = i_hwdata[7:0];
    end else if (in_exec) begin
      case (op_r)
        exec_pkg::status_bit_set:   status_register_nxt[b_r] = 1'b1;
        exec_pkg::status_bit_clear: status_register_nxt[b_r] = 1'b0;
        exec_pkg::global_irq_on:    status_register_nxt[exec_pkg::SB_I] = 1'b1;
        exec_pkg::global_irq_off:   status_register_nxt[exec_pkg::SB_I] = 1'b0;
        exec_pkg::bit_to_transfer:
          status_register_nxt[exec_pkg::SB_T] = rr_val[b_r];
        default: begin
          if (is_shift) begin
            status_register_nxt[exec_pkg::SB_Z] = sh.z;
            status_register_nxt[exec_pkg::SB_C] = sh.c;
            status_register_nxt[exec_pkg::SB_N] = sh.n;
            status_register_nxt[exec_pkg::SB_V] = sh.v;
          end
        end
      endcase
    end
  end

  // command latch and core state
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_r   <= st_idle;
      status_register_r <= exec_pkg::STATUS_REGISTER_RST;
      pc_r   <= exec_pkg::PC_RST[PC_W-1:0];
      op_r   <= exec_pkg::register_copy;
      d_r    <= 5'h00;
      r_r    <= 5'h00;
      b_r    <= 3'h0;
      k_r    <= 7'h00;
    end else begin
      st_r   <= st_nxt;
      status_register_r <= status_register_nxt;
      pc_r   <= pc_nxt;
      if (cmd_go) begin
        op_r <= exec_pkg::op_t'(i_hwdata[exec_pkg::CMD_OP_LSB +: 5]);
        d_r  <= i_hwdata[exec_pkg::CMD_D_LSB +: 5];
        r_r  <= i_hwdata[exec_pkg::CMD_R_LSB +: 5];
        b_r  <= i_hwdata[exec_pkg::CMD_B_LSB +: 3];
        k_r  <= i_hwdata[exec_pkg::CMD_K_LSB +: 7];
      end
    end
  end

  // outcome of the last instruction, shown in the status word
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      taken_r  <= 1'b0;
      cycles_r <= 2'h0;
    end else if (in_exec) begin
      taken_r  <= br_take;
      cycles_r <= two_cycle ? exec_pkg::CYC_TWO : exec_pkg::CYC_ONE;
    end
  end

  // bus-visible selectors
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rsel_r <= 5'h00;
      isel_r <= 5'h00;
    end else begin
      if (rsel_wr) rsel_r <= i_hwdata[4:0];
      if (isel_wr) isel_r <= i_hwdata[4:0];
    end
  end

  // general registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (int i = 0; i < 32; i++) gpr_r[i] <= exec_pkg::GPR_RST;
    end else if (gpr_exec_wr) begin
      gpr_r[d_r] <= gpr_exec_v;
    end else if (rdat_wr) begin
      gpr_r[rsel_r] <= i_hwdata[7:0];
    end
  end

  // io registers; out-of-range addresses are dropped
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (int i = 0; i < IO_N; i++) io_r[i] <= exec_pkg::IO_RST;
    end else if (io_wr) begin
      io_r[d_r] <= io_new;
    end else if (idat_wr && isel_ok) begin
      io_r[isel_r] <= i_hwdata[7:0];
    end
  end

endmodule // branch_bit_flag_exec

/* tb/branch_bit_flag_exec_properties.sv */
`timescale 1ns/10ps
module branch_bit_flag_exec_properties (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [2:0]  i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp
);
  logic rd_dp_r;
  logic rd_take;
  logic wr_take;

  // accepted address phases, split by direction
  assign rd_take = i_hready & i_hsel & i_htrans[1] & ~i_hwrite;
  assign wr_take = i_hready & i_hsel & i_htrans[1] & i_hwrite;

  // a read data phase lasts until hready comes back
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) rd_dp_r <= 1'b0;
    else if (i_hready) rd_dp_r <= rd_take;
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // one wait state, then the data edge
  sequence one_wait_s;
    !o_hreadyout ##1 o_hreadyout;
  endsequence
  sequence rd_of_s(a);
    rd_take && i_haddr == a ##1 one_wait_s;
  endsequence

  a_read_one_wait: assert property (rd_take |=> one_wait_s)
    else $error("read data phase without exactly one wait");
  a_write_no_wait: assert property (wr_take |=> o_hreadyout)
    else $error("write data phase stalled");
  a_ready_outside: assert property (!rd_dp_r |-> o_hreadyout)
    else $error("hreadyout low outside a read");
  a_resp_okay: assert property (!o_hresp)
    else $error("response other than okay");
  a_rdata_holds: assert property (!rd_dp_r && !rd_take |=> $stable(o_hrdata))
    else $error("read data moved without a read");
  a_reset_clean: assert property ($fell(i_rst) |-> o_hreadyout && !o_hrdata)
    else $error("bus outputs not clean after reset");
  a_cmd_reads_zero: assert property (rd_of_s(exec_pkg::OFF_CMD) |-> !o_hrdata)
    else $error("command word read back nonzero");
  a_taken_two_cycles: assert property (rd_of_s(exec_pkg::OFF_STAT) |->
    o_hrdata[3:2] != 2'h3 && (!o_hrdata[1] || o_hrdata[3:2] == 2'h2))
    else $error("taken branch not reported as two cycles");
endmodule // branch_bit_flag_exec_properties

bind branch_bit_flag_exec branch_bit_flag_exec_properties chk_i (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp)
);

/* tb/branch_bit_flag_exec_bench.sv */
`timescale 1ns/10ps
module branch_bit_flag_exec_bench;
  logic        i_sys_clk, i_rst, i_hsel, i_hwrite, o_hreadyout, o_hresp;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rv, st;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize, b;
  logic [4:0]  op, d, r;
  logic [6:0]  k;
  logic [7:0]  s, v, u, e, w;
  logic [12:0] pc, ep;
  logic        tk;
  int          err_total, n_tests, seed;

  branch_bit_flag_exec #(.PC_W(13), .IO_N(32)) dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(o_hreadyout),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp)
  );

  // core clock, 8 ns period
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, g);
    n_tests++;
    if (g !== x) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic hwait;
    int n;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 20);
    if (o_hreadyout !== 1'b1) begin
      err_total++;
      results();
    end
  endtask

  // one single word transfer; read data is taken at the last edge
  task automatic xfer(input logic wr_en, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    i_hsel <= 1'b1;
    i_haddr <= 32'(a);
    i_htrans <= 2'h2;
    i_hwrite <= wr_en;
    hwait();
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    hwait();
    rd = o_hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd, rv);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] x);
    xfer(1'b0, a, 32'h0000_0000, rv);
    chk(nm, x, rv);
  endtask

  task automatic setg(input logic [4:0] idx, input logic [7:0] val);
    wr(exec_pkg::OFF_RSEL, 32'(idx));
    wr(exec_pkg::OFF_RDAT, 32'(val));
  endtask

  // issue a command, then poll busy with a bounded count
  task automatic run(input logic [4:0] c, dd, rr, input logic [2:0] bb,
                     input logic [6:0] kk);
    int n;
    n = 0;
    wr(exec_pkg::OFF_CMD, {1'b0, kk, bb, rr, 3'h0, dd, 3'h0, c});
    do begin
      xfer(1'b0, exec_pkg::OFF_STAT, 32'h0000_0000, st);
      n++;
    end while (st[0] !== 1'b0 && n < 8);
    if (st[0] !== 1'b0) begin
      err_total++;
      results();
    end
  endtask

  // branch condition; the signed pair is inverted against the others
  function automatic logic taken_f(input logic [4:0] c, input logic [7:0] f);
    logic t;
    case (c[4:1])
      4'h0: t = f[2];
      4'h1: t = ~(f[2] ^ f[3]);
      4'h2: t = f[5];
      4'h3: t = f[6];
      4'h4: t = f[3];
      default: t = f[7];
    endcase
    return t ^ c[0];
  endfunction

  // shift result and new flags; v tracks n xor c, s h t i untouched
  function automatic logic [15:0] shf(input logic [4:0] c,
                                      input logic [7:0] x, f);
    logic [7:0] q;
    logic       cy;
    case (c)
      5'h0e: {cy, q} = {x, 1'b0};
      5'h0f: {q, cy} = {1'b0, x};
      5'h10: {cy, q} = {x, f[0]};
      5'h11: {q, cy} = {f[0], x};
      default: {q, cy} = {x[7], x};
    endcase
    f[0] = cy;
    f[1] = (q == 8'h00);
    f[2] = q[7];
    f[3] = q[7] ^ cy;
    return {f, q};
  endfunction

  initial begin
    seed = 31999;
    err_total = 0;
    n_tests = 0;
    i_rst = 1'b1;
    i_hsel = 1'b0;
    i_haddr = 32'h0000_0000;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h2;
    i_hwdata = 32'h0000_0000;
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    // reset state, an unmapped place and the write-only command word
    rdc("status_register", exec_pkg::OFF_STATUS_REGISTER, 32'h0000_0000);
    rdc("pc", exec_pkg::OFF_PC, 32'h0000_0000);
    rdc("stat", exec_pkg::OFF_STAT, 32'h0000_0000);
    wr(8'h40, 32'($random(seed)));
    rdc("unmapped", 8'h40, 32'h0000_0000);
    rdc("cmd", exec_pkg::OFF_CMD, 32'h0000_0000);
    // every branch taken and not taken, wrapping both ways first
    for (int i = 0; i < 24; i++) begin
      op = 5'(i / 2);
      do
        s = 8'($random(seed));
      while (taken_f(op, s) !== i[0]);
      pc = i < 2 ? 13'h0000 : i < 4 ? 13'h1fff : 13'($random(seed));
      k = i < 2 ? 7'h40 : i < 4 ? 7'h3f : 7'($random(seed));
      tk = i[0];
      ep = tk ? pc + {{6{k[6]}}, k} + 13'h0001 : pc + 13'h0001;
      wr(exec_pkg::OFF_STATUS_REGISTER, 32'(s));
      wr(exec_pkg::OFF_PC, 32'(pc));
      run(op, 5'($random(seed)), 5'($random(seed)), 3'($random(seed)), k);
      rdc("pc", exec_pkg::OFF_PC, 32'(ep));
      rdc("status_register", exec_pkg::OFF_STATUS_REGISTER, 32'(s));
      chk("stat", {28'h000_0000, tk ? 2'h2 : 2'h1, tk, 1'b0}, st);
    end
    // shifts and rotates with sign, carry and zero corners
    for (int i = 0; i < 15; i++) begin
      op = 5'(14 + i % 5);
      v = i < 5 ? 8'h81 : i < 10 ? 8'h01 : 8'($random(seed));
      s = 8'($random(seed));
      d = 5'($random(seed));
      setg(d, v);
      wr(exec_pkg::OFF_STATUS_REGISTER, 32'(s));
      run(op, d, 5'($random(seed)), 3'($random(seed)), 7'($random(seed)));
      {w, e} = shf(op, v, s);
      rdc("gpr", exec_pkg::OFF_RDAT, 32'(e));
      rdc("status_register", exec_pkg::OFF_STATUS_REGISTER, 32'(w));
      chk("stat", 32'h0000_0004, st);
    end
    // each status bit set and cleared by index, then interrupt on/off
    for (int i = 0; i < 18; i++) begin
      op = i < 16 ? 5'(19 + i % 2) : 5'(7 + i);
      b = 3'(i / 2);
      s = 8'($random(seed));
      w = s;
      w[i < 16 ? b : 3'h7] = (op == 5'h13 || op == 5'h17);
      wr(exec_pkg::OFF_STATUS_REGISTER, 32'(s));
      run(op, 5'($random(seed)), 5'($random(seed)), b, 7'($random(seed)));
      rdc("status_register", exec_pkg::OFF_STATUS_REGISTER, 32'(w));
      chk("stat", 32'h0000_0004, st);
    end
    // bit store, bit load and copy between two distinct registers
    for (int i = 0; i < 12; i++) begin
      op = i % 3 == 2 ? 5'h19 : 5'(21 + i % 3);
      r = 5'($random(seed));
      d = r ^ 5'h01;
      b = 3'($random(seed));
      {v, u, s} = 24'($random(seed));
      setg(r, v);
      setg(d, u);
      wr(exec_pkg::OFF_STATUS_REGISTER, 32'(s));
      run(op, d, r, b, 7'($random(seed)));
      e = op == 5'h19 ? v : u;
      w = s;
      if (op == 5'h15) w[6] = v[b];
      if (op == 5'h16) e[b] = s[6];
      rdc("gpr", exec_pkg::OFF_RDAT, 32'(e));
      rdc("status_register", exec_pkg::OFF_STATUS_REGISTER, 32'(w));
    end
    // io bit forced both ways, neighbours and flags kept
    for (int i = 0; i < 8; i++) begin
      op = 5'(12 + i % 2);
      d = 5'($random(seed));
      b = 3'($random(seed));
      {v, s} = 16'($random(seed));
      wr(exec_pkg::OFF_ISEL, 32'(d));
      wr(exec_pkg::OFF_IDAT, 32'(v));
      wr(exec_pkg::OFF_STATUS_REGISTER, 32'(s));
      run(op, d, 5'($random(seed)), b, 7'($random(seed)));
      e = v;
      e[b] = ~op[0];
      rdc("io", exec_pkg::OFF_IDAT, 32'(e));
      rdc("status_register", exec_pkg::OFF_STATUS_REGISTER, 32'(s));
      chk("stat", 32'h0000_0008, st);
    end
    // a flag write landing in the second io cycle must be refused
    wr(exec_pkg::OFF_STATUS_REGISTER, 32'h0000_005a);
    wr(exec_pkg::OFF_CMD, 32'h0000_000c);
    wr(exec_pkg::OFF_STATUS_REGISTER, 32'h0000_00a5);
    rdc("busy status_register", exec_pkg::OFF_STATUS_REGISTER, 32'h0000_005a);
    results();
  end
endmodule // branch_bit_flag_exec_bench
